// ---- rtl/dual_phase_timer_pkg.sv ----
package dual_phase_timer_pkg;

    localparam int PRESET_W = 16;
    localparam logic [PRESET_W-1:0] PRESET_MAX = 16'hffff;

    // time base: system clock period and the unit ladder, in their own units
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_1MS_PS = 1000000000;
    localparam int TICK_1MS_CYCLES = TICK_1MS_PS / CLK_PERIOD_PS;
    localparam int MS_CNT_W = 24;
    localparam int DECADE_W = 4;
    localparam logic [DECADE_W-1:0] DECADE_LAST = 4'h9;

    localparam logic [PRESET_W-1:0] CUR_RESET = 16'h0000;
    localparam logic [PRESET_W-1:0] ACC_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MODE_CONTINUOUS,
        MODE_COUNT_LIMIT,
        MODE_TIME_LIMIT
    } pulse_mode_select_e;

    typedef enum logic [1:0] {
        UNIT_1S,
        UNIT_100MS,
        UNIT_10MS,
        UNIT_1MS
    } tick_unit_select_e;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ON,
        PH_OFF,
        PH_DONE
    } phase_e;

    // a preset is either the value itself or the index of a data register
    typedef struct packed {
        logic from_reg;
        logic [PRESET_W-1:0] value;
    } preset_cfg_s;

    typedef struct packed {
        logic [MS_CNT_W-1:0] ms_cnt;
        logic [DECADE_W-1:0] dec10;
        logic [DECADE_W-1:0] dec100;
        logic [DECADE_W-1:0] dec1000;
        logic tick;
        logic en;
        phase_e phase;
        logic [PRESET_W-1:0] cur;
        logic [PRESET_W-1:0] acc;
        logic out;
    } timer_state_s;

endpackage

// ---- rtl/preset_fetch.sv ----
`timescale 1ns/100ps
module preset_fetch
    import dual_phase_timer_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire preset_cfg_s cfg_i,
    output logic [PRESET_W-1:0] dreg_idx_o,
    input wire logic [PRESET_W-1:0] dreg_data_i,
    output logic [PRESET_W-1:0] preset_o
);
    logic [PRESET_W-1:0] preset_q;
    logic [PRESET_W-1:0] preset_d;

    // indirect presets hand out the index and take the stored word back
    assign dreg_idx_o = cfg_i.value;

    always_comb begin
        preset_d = cfg_i.from_reg ? dreg_data_i : cfg_i.value;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preset_q <= CUR_RESET;
        end else begin
            preset_q <= preset_d;
        end
    end

    assign preset_o = preset_q;
endmodule

// ---- rtl/dual_phase_timer.sv ----
`timescale 1ns/100ps
// Function
// - enable rise starts on-phase time count
// - output high until on count reaches preset
// - then off phase counts, cycle repeats
// - enable low forces output low
// - count mode emits exactly preset pulses, or one cycle high for preset 0
// - time mode stops at total time limit
// - continuous mode pulses forever, reset default
// - continuous mode ignores the limit preset
// - time unit 1s, 100ms, 10ms, 1ms
// - presets are 16-bit constants or registers
// - current count cleared when timing starts
// - on preset lowered ends on phase
// - off preset lowered ends off phase
module dual_phase_timer
    import dual_phase_timer_pkg::*;
#(
    parameter int MS_CYCLES = TICK_1MS_CYCLES
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire pulse_mode_select_e pulse_mode_select_i,
    input wire tick_unit_select_e tick_unit_select_i,
    input wire preset_cfg_s on_duration_preset_i,
    input wire preset_cfg_s off_duration_preset_i,
    input wire preset_cfg_s limit_count_or_time_preset_i,
    output logic [PRESET_W-1:0] on_dreg_idx_o,
    input wire logic [PRESET_W-1:0] on_dreg_data_i,
    output logic [PRESET_W-1:0] off_dreg_idx_o,
    input wire logic [PRESET_W-1:0] off_dreg_data_i,
    output logic [PRESET_W-1:0] lim_dreg_idx_o,
    input wire logic [PRESET_W-1:0] lim_dreg_data_i,
    output logic pulse_o,
    output logic [PRESET_W-1:0] current_value_o,
    output logic [PRESET_W-1:0] limit_progress_o,
    output logic done_o
);
    localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);

    timer_state_s q;
    timer_state_s d;
    logic [PRESET_W-1:0] on_p;
    logic [PRESET_W-1:0] off_p;
    logic [PRESET_W-1:0] lim_p;
    logic ms_end;
    logic end10;
    logic end100;
    logic end1000;
    logic unit_end;
    logic limited;
    logic rise;
    logic acc_step;
    logic [PRESET_W-1:0] acc_nx;

    preset_fetch u_on_fetch (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .cfg_i(on_duration_preset_i),
        .dreg_idx_o(on_dreg_idx_o),
        .dreg_data_i(on_dreg_data_i),
        .preset_o(on_p)
    );

    preset_fetch u_off_fetch (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .cfg_i(off_duration_preset_i),
        .dreg_idx_o(off_dreg_idx_o),
        .dreg_data_i(off_dreg_data_i),
        .preset_o(off_p)
    );

    preset_fetch u_lim_fetch (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .cfg_i(limit_count_or_time_preset_i),
        .dreg_idx_o(lim_dreg_idx_o),
        .dreg_data_i(lim_dreg_data_i),
        .preset_o(lim_p)
    );

    // free-running ladder: one ms prescaler, then three decades
    assign ms_end = (q.ms_cnt == MS_LAST);
    assign end10 = ms_end && (q.dec10 == DECADE_LAST);
    assign end100 = end10 && (q.dec100 == DECADE_LAST);
    assign end1000 = end100 && (q.dec1000 == DECADE_LAST);

    always_comb begin
        case (tick_unit_select_i)
            UNIT_1S: unit_end = end1000;
            UNIT_100MS: unit_end = end100;
            UNIT_10MS: unit_end = end10;
            UNIT_1MS: unit_end = ms_end;
            default: unit_end = ms_end;
        endcase
    end

    assign rise = en_i && !q.en;
    // the limit is judged on the accumulator's next value, so the pulse that reaches it
    // runs straight into the done state and no stray restart cycle shows on the output
    assign acc_step = (pulse_mode_select_i == MODE_TIME_LIMIT && q.tick && q.phase != PH_DONE)
        || (pulse_mode_select_i == MODE_COUNT_LIMIT && q.phase == PH_OFF && q.cur >= off_p);
    assign acc_nx = (acc_step && q.acc != PRESET_MAX) ? q.acc + 1'b1 : q.acc;
    // limit only matters outside continuous mode
    assign limited = (pulse_mode_select_i != MODE_CONTINUOUS) && (acc_nx >= lim_p);

    always_comb begin
        d = q;
        d.en = en_i;
        d.ms_cnt = ms_end ? '0 : q.ms_cnt + 1'b1;
        if (ms_end) begin
            d.dec10 = (q.dec10 == DECADE_LAST) ? '0 : q.dec10 + 1'b1;
        end
        if (end10) begin
            d.dec100 = (q.dec100 == DECADE_LAST) ? '0 : q.dec100 + 1'b1;
        end
        if (end100) begin
            d.dec1000 = (q.dec1000 == DECADE_LAST) ? '0 : q.dec1000 + 1'b1;
        end
        d.tick = unit_end;
        if (!en_i) begin
            d.phase = PH_IDLE;
            d.cur = CUR_RESET;
            d.acc = ACC_RESET;
        end else if (rise) begin
            // limitation: a zero limit still shows one cycle of output before it is seen
            d.phase = PH_ON;
            d.cur = CUR_RESET;
            d.acc = ACC_RESET;
        end else begin
            case (q.phase)
                PH_ON: begin
                    if (limited) begin
                        d.phase = PH_DONE;
                    end else if (q.cur >= on_p) begin
                        d.phase = PH_OFF;
                        d.cur = CUR_RESET;
                    end else if (q.tick) begin
                        d.cur = q.cur + 1'b1;
                    end
                end
                PH_OFF: begin
                    if (limited) begin
                        d.phase = PH_DONE;
                    end else if (q.cur >= off_p) begin
                        d.phase = PH_ON;
                        d.cur = CUR_RESET;
                    end else if (q.tick) begin
                        d.cur = q.cur + 1'b1;
                    end
                end
                PH_DONE: d.cur = q.cur;
                default: d.phase = PH_IDLE;
            endcase
            // total time steps on every tick outside the done state, finished pulses at the end of each off phase
            d.acc = acc_nx;
        end
        d.out = en_i && (d.phase == PH_ON);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '{ms_cnt: '0, dec10: '0, dec100: '0, dec1000: '0, tick: 1'b0, en: 1'b0,
                   phase: PH_IDLE, cur: CUR_RESET, acc: ACC_RESET, out: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign pulse_o = q.out;
    assign current_value_o = q.cur;
    assign limit_progress_o = q.acc;
    assign done_o = (q.phase == PH_DONE);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_disabled_low: assert property (!en_i |=> !pulse_o) else $error("output high while disabled");
    a_start_clear: assert property ($rose(en_i) |=> q.cur == CUR_RESET && q.phase == PH_ON)
        else $error("timing did not start cleared in on phase");
    a_rise_high: assert property ($rose(en_i) |=> pulse_o) else $error("output not high after enable");
    a_on_end: assert property (en_i && $past(en_i) && q.phase == PH_ON && !limited && q.cur >= on_p && en_i
        |=> en_i -> (q.phase == PH_OFF && !pulse_o)) else $error("on phase did not end at preset");
    a_off_end: assert property (en_i && q.en && q.phase == PH_OFF && !limited && q.cur >= off_p
        |=> en_i -> (q.phase == PH_ON && pulse_o)) else $error("off phase did not end at preset");
    a_tick_single: assert property (q.tick |=> !q.tick) else $error("tick longer than one cycle");
    a_hold_no_tick: assert property (en_i && q.en && q.phase == PH_ON && !q.tick && q.cur < on_p && !limited
        |=> en_i -> $stable(q.cur)) else $error("count moved without tick");
    a_limit_low: assert property (q.phase == PH_DONE && en_i |=> en_i -> !pulse_o)
        else $error("output high after limit");
    a_acc_clear: assert property ($fell(en_i) |=> q.acc == ACC_RESET) else $error("accumulator not cleared");
    a_cont_never_done: assert property (pulse_mode_select_i == MODE_CONTINUOUS && q.phase != PH_DONE
        && $stable(pulse_mode_select_i) |=> q.phase != PH_DONE) else $error("continuous mode stopped");
    // state is registered, so each result is looked for one edge after its cause
    a_off_low: assert property (en_i && q.en && q.phase == PH_OFF && !limited && q.cur < off_p
        |=> !pulse_o) else $error("output high during off phase");
    a_idle_cleared: assert property (!en_i |=> q.phase == PH_IDLE && q.cur == CUR_RESET)
        else $error("state not cleared while disabled");
    a_tick_count: assert property (en_i && q.en && q.phase == PH_ON && q.tick && q.cur < on_p && !limited
        |=> q.cur == $past(q.cur) + 16'h0001) else $error("count did not step on tick");
    a_done_holds: assert property (en_i && q.phase == PH_DONE |=> q.phase == PH_DONE)
        else $error("left the done state while enabled");
    a_count_stop: assert property (pulse_mode_select_i == MODE_COUNT_LIMIT && en_i && q.en
        && q.phase == PH_OFF && q.cur >= off_p && {1'b0, q.acc} + 17'h00001 >= {1'b0, lim_p}
        |=> q.phase == PH_DONE && !pulse_o) else $error("output restarted after last pulse");
    a_time_count: assert property (pulse_mode_select_i == MODE_TIME_LIMIT && en_i && q.en && q.tick
        && q.phase != PH_DONE && q.acc < lim_p |=> q.acc == $past(q.acc) + 16'h0001)
        else $error("total time did not step on tick");
    // the ladder must never pass its last value, or a unit would stretch silently
    a_ladder_range: assert property (q.ms_cnt <= MS_LAST && q.dec10 <= DECADE_LAST
        && q.dec100 <= DECADE_LAST && q.dec1000 <= DECADE_LAST) else $error("time base out of range");

    c_full_cycle: cover property (q.phase == PH_OFF ##1 q.phase == PH_ON);
    c_count_done: cover property (pulse_mode_select_i == MODE_COUNT_LIMIT && q.phase == PH_DONE);
    c_time_done: cover property (pulse_mode_select_i == MODE_TIME_LIMIT && q.phase == PH_DONE);
    c_disable_mid: cover property (q.phase == PH_ON && !en_i);
    c_indirect_fetch: cover property (on_duration_preset_i.from_reg && q.phase == PH_OFF);
endmodule

// ---- tb/dreg_store_model.sv ----
`timescale 1ns/100ps
module dreg_store_model
    import dual_phase_timer_pkg::*;
(
    input wire logic [PRESET_W-1:0] a_i,
    input wire logic [PRESET_W-1:0] b_i,
    input wire logic [PRESET_W-1:0] c_i,
    output logic [PRESET_W-1:0] a_o,
    output logic [PRESET_W-1:0] b_o,
    output logic [PRESET_W-1:0] c_o
);
    // small words keep indirect phases short
    assign a_o = {12'h000, a_i[3:0]} + 16'h0001;
    assign b_o = {12'h000, b_i[3:0]} + 16'h0001;
    assign c_o = {12'h000, c_i[3:0]} + 16'h0001;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import dual_phase_timer_pkg::*;
    localparam int MSC = 4;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic en_i = 1'b0;
    pulse_mode_select_e mode = MODE_CONTINUOUS;
    tick_unit_select_e unit = UNIT_1MS;
    preset_cfg_s on_p = '0;
    preset_cfg_s off_p = '0;
    preset_cfg_s lim_p = '0;
    logic [PRESET_W-1:0] on_idx, off_idx, lim_idx, on_dat, off_dat, lim_dat, cur, prog;
    logic pulse, done;
    int err_count = 0;
    int samples_checked = 0;
    int tk, len, n, p1, p2;
    int runs[$];
    always #2 mclk_i = ~mclk_i;
    // the only instance here, so the timer index it stands for is never shared
    dual_phase_timer #(.MS_CYCLES(MSC)) dual_phase_timer_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(en_i),
        .pulse_mode_select_i(mode), .tick_unit_select_i(unit), .on_duration_preset_i(on_p),
        .off_duration_preset_i(off_p), .limit_count_or_time_preset_i(lim_p), .on_dreg_idx_o(on_idx),
        .on_dreg_data_i(on_dat), .off_dreg_idx_o(off_idx), .off_dreg_data_i(off_dat), .lim_dreg_idx_o(lim_idx),
        .lim_dreg_data_i(lim_dat), .pulse_o(pulse), .current_value_o(cur), .limit_progress_o(prog), .done_o(done));
    dreg_store_model dreg_store_model_i (.a_i(on_idx), .b_i(off_idx), .c_i(lim_idx),
        .a_o(on_dat), .b_o(off_dat), .c_o(lim_dat));
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // the first tick of a phase lands anywhere in its unit because the time base free-runs
    function automatic logic ok(input int l, input int p);
        return l >= (p - 1) * tk + 2 && l <= p * tk + 1;
    endfunction
    task automatic meas(input logic lvl, output int c);
        c = 0;
        while (pulse === lvl && c < 70000) begin
            c++;
            @(negedge mclk_i);
        end
    endtask
    task automatic start(input pulse_mode_select_e m, input logic f, input int a, input int b, input int l);
        int c;
        en_i = 1'b0;
        mode = m;
        on_p = {f, 16'(a)};
        off_p = {f, 16'(b)};
        lim_p = {f, 16'(l)};
        repeat (3) @(negedge mclk_i);
        en_i = 1'b1;
        c = 0;
        do begin
            @(negedge mclk_i);
            c++;
        end while (pulse !== 1'b1 && c < 4);
        ck(pulse, 1);
        ck(cur, 0);
    endtask
    initial begin
        #(4 * 90000);
        err_count++;
        close_out;
    end
    initial begin
        void'($urandom(42609));
        repeat (16) @(negedge mclk_i);
        nrst_i = 1'b1;
        for (int u = 0; u < 4; u++) begin
            unit = tick_unit_select_e'(u);
            tk = MSC * (10 ** (3 - u));
            p1 = $urandom % 2 + 1;
            p2 = $urandom % 2 + 1;
            start(MODE_CONTINUOUS, 1'b0, p1, p2, 0);
            meas(1'b1, len);
            ck(ok(len, p1), 1);
            meas(1'b0, len);
            ck(ok(len, p2), 1);
            ck(pulse, 1);
        end
        // count limit: every high run is one pulse of one on-tick, kept in a queue to check run count and length
        n = $urandom % 4 + 1;
        start(MODE_COUNT_LIMIT, 1'b0, 1, 1, n);
        len = 1;
        repeat (400) begin
            @(negedge mclk_i);
            if (pulse === 1'b1) begin
                len++;
            end else begin
                if (len > 0) runs.push_back(len);
                len = 0;
            end
        end
        ck(runs.size(), n);
        foreach (runs[i]) begin
            ck(ok(runs[i], 1), 1);
        end
        ck(prog, n);
        ck({pulse, done}, 2'b01);
        en_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        ck({prog, done}, 17'h00000);
        n = $urandom % 6 + 3;
        start(MODE_TIME_LIMIT, 1'b0, 1, 1, n);
        len = 1;
        while (done !== 1'b1 && len < 2000) begin
            @(negedge mclk_i);
            len++;
        end
        ck(len >= (n - 1) * tk + 2 && len <= n * tk + 1, 1);
        ck({pulse, prog}, {1'b0, 16'(n)});
        start(MODE_CONTINUOUS, 1'b0, 200, 200, 0);
        repeat (40) @(negedge mclk_i);
        on_p.value = 16'h0002;
        meas(1'b1, len);
        ck(len <= 4, 1);
        repeat (40) @(negedge mclk_i);
        off_p.value = 16'h0002;
        meas(1'b0, len);
        ck(len <= 4, 1);
        en_i = 1'b0;
        @(negedge mclk_i);
        ck({pulse, cur}, 17'h00000);
        n = $urandom % 16;
        start(MODE_CONTINUOUS, 1'b1, n, 3, 65535);
        ck({on_idx, lim_idx}, {16'(n), PRESET_MAX});
        ck(off_idx, 16'h0003);
        meas(1'b1, len);
        ck(ok(len, n + 1), 1);
        meas(1'b0, len);
        ck(ok(len, 4), 1);
        close_out;
    end
endmodule
